/* File: shared/wrps_pkg.sv */
// Constants and types shared by the receiver phase sequencer
package wrps_pkg;
  // Clock and link timing
  localparam int CLK_HZ       = 10_000_000;
  localparam int BIT_CLK_HZ   = 2000;
  localparam int HALF_BIT_CYC = CLK_HZ / (2 * BIT_CLK_HZ);
  localparam int MS_PER_S     = 1000;
  localparam int MS_CYC       = CLK_HZ / MS_PER_S;
  // End-of-charge and packet gap timing
  localparam int EOC_LOW_MIN  = 40;
  localparam int EOC_LOW_MS   = EOC_LOW_MIN * 60 * MS_PER_S;
  localparam int NOLOAD_S     = 40;
  localparam int NOLOAD_MS    = NOLOAD_S * MS_PER_S;
  localparam int PKT_GAP_MS   = 20;
  // Analog thresholds, mV and mA, and the charge done divider
  localparam logic [15:0] PMA_LDO_MV  = 16'h15E0;
  localparam logic [15:0] WAKE_MV_DEF = 16'h0BB8;
  localparam logic [11:0] NOLOAD_MA   = 12'h019;
  localparam logic [16:0] DONE_DIV    = 17'h00014;
  // Byte framing
  localparam int BYTE_W      = 8;
  localparam int FRAME_BITS  = 11;
  localparam int FIFO_DEPTH  = 8;
  // Packet headers, link side
  localparam logic [7:0] HDR_SIG_STR  = 8'h01;
  localparam logic [7:0] HDR_EOP      = 8'h02;
  localparam logic [7:0] HDR_CTRL_ERR = 8'h03;
  localparam logic [7:0] HDR_RECT_PWR = 8'h04;
  localparam logic [7:0] HDR_CFG      = 8'h51;
  localparam logic [7:0] HDR_ID       = 8'h71;
  localparam logic [7:0] PMA_PING_RSP = 8'hA1;
  localparam logic [7:0] PMA_RXID     = 8'hA2;
  localparam logic [7:0] PMA_EOC      = 8'hA3;
  localparam logic [7:0] PMA_STATUS   = 8'hA4;
  // End codes and fixed payloads
  localparam logic [7:0] EOP_UNKNOWN  = 8'h00;
  localparam logic [7:0] EOP_CHG_DONE = 8'h01;
  localparam logic [7:0] EOP_OVERTEMP = 8'h03;
  localparam logic [7:0] SIG_STR_VAL  = 8'hFF;
  // Phase machine, one-hot
  typedef enum logic [4:0] {
    ST_SEL = 5'h01, ST_PING = 5'h02, ST_IDCFG = 5'h04,
    ST_XFER = 5'h08, ST_END = 5'h10
  } wrps_state_t;
  // Packet loader
  typedef enum logic [2:0] {
    PK_IDLE = 3'h1, PK_LOAD = 3'h2, PK_DRAIN = 3'h4
  } wrps_pkt_t;
  // Bit encoder
  typedef enum logic [1:0] {ENC_IDLE = 2'h1, ENC_SEND = 2'h2} wrps_enc_t;
endpackage

/* File: verilog/wrps_fifo.sv */
// Byte FIFO between packet loader and bit encoder
`timescale 1ns/1ps
`default_nettype none
module wrps_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  // Fill side
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  // Drain side
  output logic                  outValid,
  output logic [WIDTH-1:0]      outData,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];      // Storage
  logic [AW-1:0]    wr_q, wr_d;       // Write pointer
  logic [AW-1:0]    rd_q, rd_d;       // Read pointer
  logic [AW:0]      cnt_q, cnt_d;     // Fill level
  logic             push, pop;

  assign inReady  = (cnt_q != (AW+1)'(DEPTH));
  assign outValid = (cnt_q != '0);
  assign outData  = mem[rd_q];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  // Pointer and level update
  always_comb begin
    wr_d  = push ? AW'(wr_q + 1'b1) : wr_q;
    rd_d  = pop ? AW'(rd_q + 1'b1) : rd_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    if (flush) begin
      wr_d  = '0;
      rd_d  = '0;
      cnt_d = '0;
    end
  end

  // Registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage has no reset, content is guarded by the level
  always_ff @(posedge mclk) begin
    if (push && !flush) begin
      mem[wr_q] <= inData;
    end
  end
endmodule // wrps_fifo
`default_nettype wire

/* File: verilog/wrps_biphase_tx.sv */
// Differential bi-phase byte encoder driving load modulation
`timescale 1ns/1ps
`default_nettype none
module wrps_biphase_tx
  import wrps_pkg::*;
#(
  parameter int HALF_P = HALF_BIT_CYC  // Half bit
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        abort,
  // Byte stream in
  input  wire logic        byteValid,
  input  wire logic [7:0]  byteData,
  output logic             byteReady,
  // Modulator
  output logic             modOut
);
  wrps_enc_t   st_q, st_d;           // Encoder state
  logic [10:0] frame_q, frame_d;     // Bits left, LSB first
  logic [3:0]  bit_q, bit_d;         // Bit index in frame
  logic        half_q, half_d;       // Second half of bit
  logic [11:0] cnt_q, cnt_d;         // Half-bit timer
  logic        mod_q, mod_d;         // Modulator level
  logic [10:0] newFrame;

  assign byteReady = (st_q == ENC_IDLE);
  assign modOut    = mod_q;
  // Start 0, data, odd parity, stop 1
  assign newFrame  = {1'b1, ~^byteData, byteData, 1'b0};

  // Every bit opens with a toggle, a one toggles again mid-bit
  always_comb begin
    st_d = st_q; frame_d = frame_q; bit_d = bit_q;
    half_d = half_q; cnt_d = cnt_q; mod_d = mod_q;
    case (st_q)
      ENC_IDLE: begin
        if (byteValid) begin
          st_d = ENC_SEND; frame_d = newFrame; bit_d = 4'h0;
          half_d = 1'b0; mod_d = ~mod_q;
          cnt_d = 12'(HALF_P - 1);
        end
      end
      ENC_SEND: begin
        if (cnt_q != 12'h000) begin
          cnt_d = cnt_q - 12'h001;
        end else if (!half_q) begin
          // Mid-bit: narrow transitions mark a one
          half_d = 1'b1;
          cnt_d = 12'(HALF_P - 1);
          if (frame_q[0]) mod_d = ~mod_q;
        end else if (bit_q == 4'(FRAME_BITS - 1)) begin
          st_d = ENC_IDLE;
        end else begin
          half_d = 1'b0; bit_d = bit_q + 4'h1;
          frame_d = {1'b0, frame_q[10:1]};
          cnt_d = 12'(HALF_P - 1);
          mod_d = ~mod_q;
        end
      end
      default: st_d = ENC_IDLE;
    endcase
    if (abort) begin
      st_d = ENC_IDLE;
      mod_d = mod_q;
    end
  end

  // Registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q <= ENC_IDLE; frame_q <= '0; bit_q <= '0;
      half_q <= 1'b0; cnt_q <= '0; mod_q <= 1'b0;
    end else begin
      st_q <= st_d; frame_q <= frame_d; bit_q <= bit_d;
      half_q <= half_d; cnt_q <= cnt_d; mod_q <= mod_d;
    end
  end
endmodule // wrps_biphase_tx
`default_nettype wire

/* File: verilog/wrps_sequencer.sv */
// Dual-mode receiver phase sequencer, top module
// Contract
// - Stay in selection until supply above wake
// - Send nothing before leaving selection
// - First ping packet is signal strength
// - After signal strength, go to identification
// - Sending end packets in ping stays there
// - Send identification, configuration, then power transfer
// - Transfer: control error, rectified power, end
// - PMA answers digital ping correctly
// - Send receiver identifier when transmitter supports it
// - PMA regulator on in transfer above 5.6V
// - End-of-charge: output off, repeat until unpowered
// - Low current 40 minutes forces end-of-charge; the low-current timer runs only in PMA transfer
// - Charge done current is limit over twenty
// - Below 25 mA counts as no load
// - No load 40 seconds forces end-of-charge; the no-load timer runs only in PMA transfer
// - Bi-phase bits at 2 kHz
// - Byte frame: start, 8 data, parity, stop
// - Fault or request: regulator off, repeat end
`timescale 1ns/1ps
`default_nettype none
module wrps_sequencer
  import wrps_pkg::*;
#(
  parameter int          MS_CYC_P      = MS_CYC,
  parameter int          HALF_P        = HALF_BIT_CYC,
  parameter int          EOC_LOW_MS_P  = EOC_LOW_MS,
  parameter int          NOLOAD_MS_P   = NOLOAD_MS,
  parameter int          PKT_GAP_MS_P  = PKT_GAP_MS,
  parameter logic [15:0] WAKE_MV       = WAKE_MV_DEF,
  parameter logic [7:0]  RX_ID         = 8'h5A, // Arbitrary value
  parameter logic [7:0]  CFG_BYTE      = 8'h10
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Analog measurements, mV and mA
  input  wire logic [15:0] rectifiedSupplyLevel,
  input  wire logic [11:0] outputCurrent,
  input  wire logic [11:0] currentLimitLevel,
  // Mode and end requests
  input  wire logic        pmaDetect,
  input  wire logic        pmaIdSupport,
  input  wire logic        thermalShutdown,
  input  wire logic        disableReq,
  input  wire logic        chargeEndReq,
  // Control payloads
  input  wire logic [7:0]  controlError,
  input  wire logic [7:0]  rectPower,
  // Outputs
  output logic             modOut,
  output logic             ldoEnable,
  output logic             xferActive,
  output logic             eocActive,
  output logic             pmaActive
);
  //////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  localparam int SW = 61;
  logic [SW-1:0] syncA_q, syncB_q;   // Two-stage catch of pins
  logic [15:0]   rectS;              // Supply level
  logic [11:0]   curS, limS;         // Output current, limit
  logic          pmaS, idSupS;       // Mode strap, id support
  logic          thermS, disS, chgS; // End requests
  logic [7:0]    ceS, rpS;           // Payload words

  // Words move slowly against the clock, so two stages suffice
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      syncA_q <= '0;
      syncB_q <= '0;
    end else begin
      syncA_q <= {rectifiedSupplyLevel, outputCurrent, currentLimitLevel,
                  pmaDetect, pmaIdSupport, thermalShutdown, disableReq,
                  chargeEndReq, controlError, rectPower};
      syncB_q <= syncA_q;
    end
  end
  assign {rectS, curS, limS, pmaS, idSupS, thermS, disS, chgS, ceS, rpS}
    = syncB_q;

  //////////////////////////////////////////////////////////////////////////
  // Level decisions
  logic        awake;                // Above wake threshold
  logic        endReq;               // Any end request
  logic [16:0] curX20;               // Current times divider
  logic        lowCur, noLoad;       // Charge done, no load
  logic [7:0]  eopCode;              // End reason code

  assign awake  = (rectS > WAKE_MV);
  assign endReq = thermS || disS || chgS;
  // Compare current*20 to limit, no divider needed
  assign curX20 = 17'(curS) * DONE_DIV;
  assign lowCur = (curX20 < 17'(limS));
  assign noLoad = (curS < NOLOAD_MA);
  // Thermal outranks charge end
  assign eopCode = thermS ? EOP_OVERTEMP :
                   chgS   ? EOP_CHG_DONE : EOP_UNKNOWN;

  //////////////////////////////////////////////////////////////////////////
  // Millisecond timers
  logic [31:0] ms_q, ms_d;           // Prescaler
  logic [31:0] gap_q, gap_d;         // Gap between packets
  logic [31:0] low_q, low_d;         // Low current time
  logic [31:0] idle_q, idle_d;       // No load time
  logic        msTick, gapOk, lowHit, idleHit;
  wrps_state_t st_q, st_d;           // Phase
  logic        pma_q, pma_d;         // Held mode
  logic        pkStart;              // Packet request

  assign msTick  = (ms_q == 32'(MS_CYC_P - 1));
  assign gapOk   = (gap_q == 32'h0000_0000);
  assign lowHit  = (low_q == 32'(EOC_LOW_MS_P));
  assign idleHit = (idle_q == 32'(NOLOAD_MS_P));

  // Low-current and no-load timers only run in PMA transfer, saturate at their limit
  always_comb begin
    ms_d = msTick ? 32'h0000_0000 : ms_q + 32'h0000_0001;
    gap_d = gap_q;
    if (pkStart) gap_d = 32'(PKT_GAP_MS_P);
    else if (msTick && !gapOk) gap_d = gap_q - 32'h0000_0001;
    low_d = 32'h0000_0000;
    idle_d = 32'h0000_0000;
    if (st_q == ST_XFER && pma_q) begin
      if (lowCur) low_d = (msTick && !lowHit) ? low_q + 32'h1 : low_q;
      if (noLoad) idle_d = (msTick && !idleHit) ? idle_q + 32'h1 : idle_q;
    end
    if (!awake) gap_d = 32'h0000_0000;
  end

  // Registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ms_q <= '0; gap_q <= '0; low_q <= '0; idle_q <= '0;
    end else begin
      ms_q <= ms_d; gap_q <= gap_d; low_q <= low_d; idle_q <= idle_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Packet loader: header, payload, checksum into the FIFO
  wrps_pkt_t  pk_q, pk_d;            // Loader state
  logic [1:0] idx_q, idx_d;          // Byte index
  logic [7:0] hdr_q, hdr_d;          // Current header
  logic [7:0] pay_q, pay_d;          // Current payload
  logic [7:0] pkHdr, pkPay;          // Requested packet
  logic       push, fifoInReady;
  logic [7:0] pushData;
  logic       fifoOutValid, encReady;
  logic [7:0] fifoOutData;
  logic       pkIdle, pkDone;

  assign pkIdle = (pk_q == PK_IDLE);
  // Done only once the last bit has left the modulator
  assign pkDone = (pk_q == PK_DRAIN) && !fifoOutValid && encReady;

  // Loader next state; stalls while the FIFO is full
  always_comb begin
    pk_d = pk_q; idx_d = idx_q; hdr_d = hdr_q; pay_d = pay_q;
    push = 1'b0; pushData = 8'h00;
    case (pk_q)
      PK_IDLE: begin
        if (pkStart) begin
          pk_d = PK_LOAD; idx_d = 2'h0; hdr_d = pkHdr; pay_d = pkPay;
        end
      end
      PK_LOAD: begin
        push = 1'b1;
        if (idx_q == 2'h0) pushData = hdr_q;
        else if (idx_q == 2'h1) pushData = pay_q;
        else pushData = hdr_q ^ pay_q;
        if (fifoInReady) begin
          if (idx_q == 2'h2) pk_d = PK_DRAIN;
          else idx_d = idx_q + 2'h1;
        end
      end
      PK_DRAIN: if (pkDone) pk_d = PK_IDLE;
      default: pk_d = PK_IDLE;
    endcase
    if (!awake) pk_d = PK_IDLE;   // Power gone drops the packet
  end

  // Registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pk_q <= PK_IDLE; idx_q <= '0; hdr_q <= '0; pay_q <= '0;
    end else begin
      pk_q <= pk_d; idx_q <= idx_d; hdr_q <= hdr_d; pay_q <= pay_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Phase machine
  logic       sub_q, sub_d;          // Second step of id phase
  logic       alt_q, alt_d;          // Alternates transfer packets
  logic [7:0] pingHdr, endHdr;
  logic       endHit;

  // PMA answers the ping with its own response code
  assign pingHdr = pma_q ? PMA_PING_RSP : HDR_SIG_STR;
  assign endHdr  = pma_q ? PMA_EOC : HDR_EOP;
  // Timed end-of-charge is a PMA matter
  assign endHit  = endReq || (pma_q && (lowHit || idleHit));

  always_comb begin
    st_d = st_q; pma_d = pma_q; sub_d = sub_q; alt_d = alt_q;
    pkStart = 1'b0; pkHdr = 8'h00; pkPay = 8'h00;
    case (st_q)
      ST_SEL: begin
        // Nothing is sent here
        if (awake) begin
          st_d = ST_PING; pma_d = pmaS; sub_d = 1'b0;
        end
      end
      ST_PING: begin
        if (pkDone && hdr_q == pingHdr) begin
          st_d = ST_IDCFG; sub_d = 1'b0;
        end else if (pkIdle && gapOk) begin
          // End packets keep the phase where it is
          pkStart = 1'b1;
          pkHdr = endReq ? endHdr : pingHdr;
          pkPay = endReq ? eopCode : SIG_STR_VAL;
        end
      end
      ST_IDCFG: begin
        if (pkDone) begin
          if (pma_q || sub_q) st_d = ST_XFER;
          else sub_d = 1'b1;
        end else if (pkIdle && pma_q && !idSupS) begin
          st_d = ST_XFER;
        end else if (pkIdle && gapOk) begin
          pkStart = 1'b1;
          pkHdr = pma_q ? PMA_RXID : (sub_q ? HDR_CFG : HDR_ID);
          pkPay = (!pma_q && sub_q) ? CFG_BYTE : RX_ID;
        end
      end
      ST_XFER: begin
        if (endHit) begin
          st_d = ST_END;
        end else if (pkIdle && gapOk) begin
          pkStart = 1'b1;
          alt_d = ~alt_q;
          if (pma_q) pkHdr = PMA_STATUS;
          else pkHdr = alt_q ? HDR_RECT_PWR : HDR_CTRL_ERR;
          pkPay = alt_q ? rpS : ceS;
        end
      end
      ST_END: begin
        // Repeat end packets until the supply collapses
        if (pkIdle && gapOk) begin
          pkStart = 1'b1; pkHdr = endHdr; pkPay = eopCode;
        end
      end
      default: st_d = ST_SEL;
    endcase
    // Only loss of power releases the held mode
    if (!awake) begin
      st_d = ST_SEL; pma_d = 1'b0; sub_d = 1'b0; alt_d = 1'b0;
    end
  end

  // Registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q <= ST_SEL; pma_q <= 1'b0; sub_q <= 1'b0; alt_q <= 1'b0;
    end else begin
      st_q <= st_d; pma_q <= pma_d; sub_q <= sub_d; alt_q <= alt_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Status outputs
  logic ldo_q, ldo_d;                // Regulator enable
  logic xfer_q, xfer_d;              // Transfer established
  logic eoc_q, eoc_d;                // Ending state

  // Regulator off on any end condition
  always_comb begin
    ldo_d = (st_q == ST_XFER) && !endHit &&
            (!pma_q || rectS > PMA_LDO_MV);
    xfer_d = (st_q == ST_XFER) || (st_q == ST_END);
    eoc_d = (st_q == ST_END);
  end

  // Registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ldo_q <= 1'b0; xfer_q <= 1'b0; eoc_q <= 1'b0;
    end else begin
      ldo_q <= ldo_d; xfer_q <= xfer_d; eoc_q <= eoc_d;
    end
  end

  assign ldoEnable  = ldo_q;
  assign xferActive = xfer_q;
  assign eocActive  = eoc_q;
  assign pmaActive  = pma_q;

  //////////////////////////////////////////////////////////////////////////
  // Byte FIFO and encoder; encoder stalls drain, loader waits on full
  wrps_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) uFifo (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .flush    (!awake),
    .inValid  (push),
    .inData   (pushData),
    .inReady  (fifoInReady),
    .outValid (fifoOutValid),
    .outData  (fifoOutData),
    .outReady (encReady)
  );

  wrps_biphase_tx #(.HALF_P(HALF_P)) uTx (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .abort     (!awake),
    .byteValid (fifoOutValid),
    .byteData  (fifoOutData),
    .byteReady (encReady),
    .modOut    (modOut)
  );
endmodule // wrps_sequencer
`default_nettype wire

/* File: dv/wrps_tx_model.sv */
// Transmitter model: decodes bi-phase load modulation into bytes
`timescale 1ns/1ps
`default_nettype none
module wrps_tx_model
  import wrps_pkg::*;
#(
  parameter int HALF_P = HALF_BIT_CYC
) (
  // Clock and reset
  input  wire logic  mclk,
  input  wire logic  rst_n,
  // Coil side
  input  wire logic  modOut,
  // Decoded bytes
  output logic       rxValid,
  output logic [7:0] rxByte,
  output logic       rxFrameOk
);
  localparam int BIT = 2 * HALF_P;  // Cycles per bit
  localparam int Q   = HALF_P / 2;  // Tolerance around mid-bit
  logic        lastQ;    // Level at previous edge
  logic        busyQ;    // Inside a frame
  logic        midQ;     // Mid-bit toggle seen
  logic        edgeOkQ;  // Every bit opened with a toggle
  logic [3:0]  idxQ;     // Bit slot
  logic [10:0] frmQ;     // Frame bits, start bit first
  int          cntQ;     // Cycles into bit
  logic        tog;      // Level changed since last edge
  assign tog = modOut != lastQ;
  //////////////////////////////////////////////////////////////////////////
  // Timer starts on the first toggle after idle; it never resyncs, so
  // any drift in the encoder's bit time shows up as a stray toggle
  always_ff @(posedge mclk) begin
    rxValid <= 1'b0;
    lastQ   <= modOut;
    if (!rst_n) begin
      busyQ <= 1'b0;
    end else if (!busyQ) begin
      busyQ   <= tog;
      cntQ    <= 1;
      idxQ    <= 4'h0;
      midQ    <= 1'b0;
      edgeOkQ <= 1'b1;
    end else begin
      cntQ <= (cntQ == BIT - 1) ? 0 : cntQ + 1;
      if (tog && cntQ > Q && cntQ < BIT - Q) begin
        midQ <= 1'b1;  // Narrow transitions mark a one
      end else if (tog != (cntQ == 0)) begin
        edgeOkQ <= 1'b0;  // Stray toggle or missing bit edge
      end
      if (cntQ == BIT - 1) begin
        frmQ[idxQ] <= midQ;
        idxQ       <= idxQ + 4'h1;
        midQ       <= 1'b0;
        busyQ      <= (idxQ != 4'hA);
        rxValid    <= (idxQ == 4'hA);
        rxByte     <= frmQ[8:1];
        // Start low, odd parity, stop high
        rxFrameOk  <= edgeOkQ && !frmQ[0] && midQ &&
                      (frmQ[9] == ~^frmQ[8:1]);
      end
    end
  end
endmodule // wrps_tx_model
`default_nettype wire

/* File: dv/wrps_sequencer_chk.sv */
// Concurrent checks on the phase sequencer ports
`timescale 1ns/1ps
`default_nettype none
module wrps_sequencer_chk
  import wrps_pkg::*;
#(
  parameter logic [15:0] WAKE_MV = WAKE_MV_DEF  // Wake threshold, mV
) (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst_n,
  // Sequencer inputs
  input wire logic [15:0] rectifiedSupplyLevel,
  input wire logic        pmaDetect,
  input wire logic        thermalShutdown,
  input wire logic        disableReq,
  input wire logic        chargeEndReq,
  // Sequencer outputs
  input wire logic        modOut,
  input wire logic        ldoEnable,
  input wire logic        xferActive,
  input wire logic        eocActive,
  input wire logic        pmaActive
);
  logic awake;   // Supply above wake threshold
  logic endReq;  // Any end request
  assign awake  = rectifiedSupplyLevel > WAKE_MV;
  assign endReq = thermalShutdown || disableReq || chargeEndReq;
  // Single domain; reset aborts every attempt
  default clocking cbChk @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////////////////////////////////////
  // Six cycles cover the input sync and the encoder abort
  a_sleep_quiet: assert property (
    !awake [*6] |=> $stable(modOut))
    else $error("modulation changed while asleep");
  a_sleep_idle: assert property (
    !awake [*6] |-> !xferActive && !ldoEnable)
    else $error("active while asleep");
  a_wake_speaks: assert property (
    $rose(awake) |-> ##[1:30] $changed(modOut))
    else $error("no packet after wake");
  a_mode_latch: assert property (
    $rose(awake) ##0 $stable(pmaDetect) [*6] |=> pmaActive == pmaDetect)
    else $error("mode not taken at wake");
  a_mode_held: assert property (
    xferActive && $past(xferActive) && awake |-> $stable(pmaActive))
    else $error("mode changed in transfer");
  a_ldo_start: assert property (
    $rose(ldoEnable) |-> xferActive && !eocActive)
    else $error("regulator on outside transfer");
  a_ldo_volt: assert property (
    (pmaActive && rectifiedSupplyLevel <= PMA_LDO_MV) [*5] |-> !ldoEnable)
    else $error("regulator on at low supply");
  a_end_ldo_off: assert property (
    endReq [*5] |-> !ldoEnable)
    else $error("regulator on during end request");
  a_eoc_ldo_off: assert property (
    eocActive [*2] |-> !ldoEnable)
    else $error("regulator on during end of charge");
  a_eoc_stays: assert property (
    eocActive && awake |=> eocActive && xferActive)
    else $error("end of charge left while powered");
endmodule // wrps_sequencer_chk

bind wrps_sequencer wrps_sequencer_chk #(
  .WAKE_MV(WAKE_MV)
) u_wrps_sequencer_chk (
  .mclk, .rst_n, .rectifiedSupplyLevel, .pmaDetect, .thermalShutdown,
  .disableReq, .chargeEndReq, .modOut, .ldoEnable, .xferActive,
  .eocActive, .pmaActive
);
`default_nettype wire

/* File: dv/test_wrps_sequencer.sv */
// Self-checking bench for the receiver phase sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) begin \
      err_total++; \
      $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end
module test_wrps_sequencer;
  import wrps_pkg::*;
  localparam int         MSC  = 10;     // Shortened millisecond, cycles
  localparam int         NOL  = 20;     // Shortened no-load time, ms
  localparam int         LOW  = 50;     // Shortened low-current time, ms
  localparam logic [7:0] RXID = 8'h3C;  // Arbitrary receiver identifier
  localparam logic [7:0] CFGB = 8'h22;  // Arbitrary configuration byte
  logic        mclk, rst_n, pmaDet, pmaIdSup, therm, dis, chgEnd;
  logic [15:0] rect;                  // Rectified supply, mV
  logic [11:0] cur, lim;              // Output current and limit, mA
  logic [7:0]  ce, rp;                // Transfer payloads
  logic        modOut, ldoEn, xfer, eoc, pma;
  logic        rxValid, rxFrameOk;
  logic [7:0]  rxByte, expB;
  logic [7:0]  expQ[$];               // Bytes owed to the transmitter
  int          err_total, compares, k, n, tEnd;

  wrps_sequencer #(.MS_CYC_P(MSC), .EOC_LOW_MS_P(LOW), .NOLOAD_MS_P(NOL),
    .PKT_GAP_MS_P(1), .HALF_P(20), .RX_ID(RXID), .CFG_BYTE(CFGB))
    u_wrps_sequencer (
    .mclk(mclk), .rst_n(rst_n), .rectifiedSupplyLevel(rect),
    .outputCurrent(cur), .currentLimitLevel(lim), .pmaDetect(pmaDet),
    .pmaIdSupport(pmaIdSup), .thermalShutdown(therm), .disableReq(dis),
    .chargeEndReq(chgEnd), .controlError(ce), .rectPower(rp),
    .modOut(modOut), .ldoEnable(ldoEn), .xferActive(xfer),
    .eocActive(eoc), .pmaActive(pma));
  wrps_tx_model #(.HALF_P(20)) u_wrps_tx_model (.mclk(mclk),
    .rst_n(rst_n), .modOut(modOut), .rxValid(rxValid), .rxByte(rxByte),
    .rxFrameOk(rxFrameOk));

  always #50 mclk = ~mclk;
  //////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Packet: header, payload, xor checksum
  task automatic push(input logic [7:0] h, input logic [7:0] p);
    expQ.push_back(h);
    expQ.push_back(p);
    expQ.push_back(h ^ p);
  endtask
  // Wait until at most left bytes are owed; a hang ends the run
  task automatic drain(input int left);
    int i;
    for (i = 0; i < 20000 && expQ.size() > left; i++)
      @(negedge mclk);
    if (expQ.size() > left) begin
      `CHK(expQ.size(), left)
      print_verdict();
    end
  endtask
  // Power loss and return: reset below wake, expect silence, then wake
  task automatic power_up(input logic p, input logic ids,
                          input logic [15:0] v);
    expQ.delete();
    rect = 16'($urandom_range(WAKE_MV_DEF));
    rst_n = 1'b0;
    repeat (8) @(negedge mclk);
    rst_n = 1'b1;
    pmaDet = p;
    pmaIdSup = ids;
    repeat (20) @(negedge mclk);
    `CHK(modOut, 1'b0)
    `CHK(xfer, 1'b0)
    rect = v;
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Every decoded byte against the oldest note; extras meet an unknown
  always @(negedge mclk) begin
    if (rxValid === 1'b1) begin
      `CHK(rxFrameOk, 1'b1)
      expB = expQ.size() ? expQ.pop_front() : 8'hXX;
      `CHK(rxByte, expB)
    end
  end
  // Main sequence
  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    rect = 16'h0000;
    cur = 12'h1F4;
    lim = 12'h3E8;
    pmaDet = 1'b0;
    pmaIdSup = 1'b0;
    therm = 1'b1;  // Held across wake: ping must end, not advance
    dis = 1'b0;
    chgEnd = 1'b0;
    err_total = 0;
    compares = 0;
    void'($urandom(16));
    ce = 8'($urandom);
    rp = 8'($urandom);
    // Inductive mode, woken just above the threshold
    power_up(1'b0, 1'b0, WAKE_MV_DEF + 16'h0001);
    push(HDR_EOP, EOP_OVERTEMP);
    drain(2);
    therm = 1'b0;
    push(HDR_SIG_STR, SIG_STR_VAL);
    drain(3);
    `CHK(xfer, 1'b0)
    push(HDR_ID, RXID);
    push(HDR_CFG, CFGB);
    drain(0);
    push(HDR_CTRL_ERR, ce);
    push(HDR_RECT_PWR, rp);
    repeat (4) @(negedge mclk);
    `CHK(xfer, 1'b1)
    drain(2);
    chgEnd = 1'b1;                   // Lands mid packet
    push(HDR_EOP, EOP_CHG_DONE);
    push(HDR_EOP, EOP_CHG_DONE);
    drain(0);
    `CHK({xfer, eoc, ldoEn}, 3'h6)
    chgEnd = 1'b0;
    // Magnetic mode: no-load end with identifier, then low-current end
    for (k = 0; k < 2; k++) begin
      dis = (k == 0);
      cur = 12'h1F4;
      power_up(1'b1, k == 0, PMA_LDO_MV);
      if (k == 0) begin
        push(PMA_EOC, EOP_UNKNOWN);
        drain(2);
        dis = 1'b0;
      end
      push(PMA_PING_RSP, SIG_STR_VAL);
      if (k == 0)
        push(PMA_RXID, RXID);
      push(PMA_STATUS, ce);
      push(PMA_STATUS, rp);
      drain(2);
      pmaDet = 1'b0;                    // Mode must not follow this
      `CHK({xfer, pma, ldoEn}, 3'h6)
      rect = PMA_LDO_MV + 16'h0001;
      repeat (6) @(negedge mclk);
      `CHK({pma, ldoEn}, 2'h3)
      // 24 mA is no load; 49 mA sits just under a twentieth of 1000 mA
      cur = (k == 0) ? 12'h018 : 12'h031;
      tEnd = (k == 0 ? NOL : LOW) * MSC;
      for (n = 0; n < tEnd + 40 && eoc !== 1'b1; n++)
        @(negedge mclk);
      `CHK(n >= tEnd - MSC && n <= tEnd + 8, 1'b1)
      `CHK({xfer, ldoEn}, 2'h2)
      push(PMA_EOC, EOP_UNKNOWN);
      push(PMA_EOC, EOP_UNKNOWN);
      drain(0);
      `CHK({xfer, eoc}, 2'h3)
    end
    print_verdict();
  end
endmodule // test_wrps_sequencer
`default_nettype wire
